// ===== design/msd_core.sv
`timescale 1ns/1ns
`default_nettype none
module msd_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // read-only store
    output logic [9:0] rosAddr,
    input wire logic [15:0] rosData,
    // core memory
    output logic [14:0] memAddr,
    output logic memAddrOe,
    output logic memStart,
    output logic memWrite,
    output logic memFull,
    output logic [7:0] memWrData,
    input wire logic [7:0] memRdData,
    // dma
    input wire logic dmaReq,
    output logic dmaGrant,
    // i/o bus and lines
    input wire logic [7:0] ioIn,
    output logic [2:0] ioCtl,
    input wire logic ioRequest,
    input wire logic ioReply,
    input wire logic extIrq,
    input wire logic intIrq,
    input wire logic serialIn,
    // console
    input wire logic startReq,
    output logic halted
);
    // ==========================================
    // input synchronisers
    logic [14:0] syncA_q, syncB_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= {dmaReq, ioRequest, ioReply, extIrq, intIrq,
                        serialIn, startReq, ioIn};
            syncB_q <= syncA_q;
        end
    end
    logic dmaS, reqS, replyS, extS, intS, serS, startS;
    logic [7:0] ioS;
    assign {dmaS, reqS, replyS, extS, intS, serS, startS, ioS} = syncB_q;

    // ==========================================
    // state
    logic [9:0] pc_q, pc_d;
    logic [15:0] cmd_q, cmd_d;
    logic [7:0] t_q, t_d, m_q, m_d, n_q, n_d, u_q, u_d, wrData_q, wrData_d;
    logic [2:0] ioc_q, ioc_d, flags_q, flags_d, memCnt_q, memCnt_d;
    logic link_q, link_d, halt_q, halt_d, serEn_q, serEn_d, startPrev_q;
    logic memFull_q, memFull_d, memWr_q, memWr_d, grant_q, grant_d;
    logic [7:0] file_q [1:15];
    logic fileWe;
    logic [3:0] fileIdx;
    logic [7:0] fileVal;

    function automatic logic [15:0] modWord(input logic [15:0] w,
                                            input logic [7:0] u);
        modWord = w;
        if (w[15:12] == 4'h0 || (w[15] && w[2:0] == 3'h7)) begin
            modWord[15:8] = w[15:8] | u;
        end
    endfunction

    // ==========================================
    // decode and datapath
    msd_pkg::msd_cmd_t c;
    logic isLit, isOpr, run, redirect, memBusy, stall, zero, ovf, cy;
    logic [9:0] target;
    logic [7:0] lit, tSrc, aBus, bBus, bEff, res, flags0;
    logic [8:0] sum;
    always_comb begin
        c = cmd_q;
        lit = cmd_q[7:0];
        isLit = c.op != msd_pkg::OP_EXEC && c.op < msd_pkg::OP_CTRL;
        isOpr = c.op >= msd_pkg::OP_CTRL;
        tSrc = ioc_q[2] ? ioS : t_q;
        flags0 = {extS, serEn_q & serS, replyS, intS, reqS, flags_q};
        aBus = (c.sel == 4'h0) ? flags0 : file_q[c.sel];
        bBus = isLit ? lit
             : (({8{c.opt[1]}} & tSrc) | ({8{c.opt[2]}} & ~tSrc));
        bEff = bBus;
        sum = 9'h000;
        res = aBus;
        cy = link_q;
        unique case (c.op)
            msd_pkg::OP_ADD, msd_pkg::OP_ADDL: begin
                sum = {1'b0, aBus} + {1'b0, bBus};
                res = sum[7:0];
                cy = sum[8];
            end
            msd_pkg::OP_SUB, msd_pkg::OP_CMP: begin
                bEff = ~bBus;
                sum = {1'b0, aBus} + {1'b0, ~bBus} + 9'h001;
                res = sum[7:0];
                cy = sum[8];
            end
            msd_pkg::OP_SHF: begin
                res = {aBus[6:0], link_q};
                cy = aBus[7];
            end
            msd_pkg::OP_AND: res = aBus & bBus;
            msd_pkg::OP_OR: res = aBus | bBus;
            msd_pkg::OP_XOR: res = aBus ^ bBus;
            msd_pkg::OP_COPY: res = bBus;
            default: res = aBus;
        endcase
        zero = (res == 8'h00);
        ovf = (c.op == msd_pkg::OP_SHF) ? aBus[7]
            : (aBus[7] == bEff[7]) && (res[7] != aBus[7]);
        memBusy = memCnt_q != 3'h0;
        stall = halt_q
            || (c.op == msd_pkg::OP_MEM && (memBusy || dmaS || grant_q))
            || (((c.op == msd_pkg::OP_LOADR && c.sel[3:1] == 3'h1)
                 || (isOpr && c.dest[2:1] == 2'h1))
                && (memBusy || grant_q))
            || (isOpr && (c.opt[1] | c.opt[2]) && !memWr_q && memBusy
                && memCnt_q <= msd_pkg::RD_LOAD_CLK);
        run = !stall;
    end

    // ==========================================
    // next state
    always_comb begin
        pc_d = pc_q;
        cmd_d = cmd_q;
        t_d = t_q;
        m_d = m_q;
        n_d = n_q;
        u_d = u_q;
        ioc_d = ioc_q;
        flags_d = flags_q;
        link_d = link_q;
        halt_d = halt_q;
        serEn_d = serEn_q;
        memCnt_d = memCnt_q;
        memFull_d = memFull_q;
        memWr_d = memWr_q;
        wrData_d = wrData_q;
        fileWe = 1'b0;
        fileIdx = c.sel;
        fileVal = res;
        redirect = 1'b0;
        target = {pc_q[9:8], pc_q[7:0] + 8'h01};
        // memory sequencer runs on its own; T free after the load
        if (memBusy) begin
            memCnt_d = (memCnt_q == (memFull_q ? msd_pkg::FULL_CLKS
                        : msd_pkg::HALF_CLKS)) ? 3'h0
                        : memCnt_q + 3'h1;
        end
        grant_d = dmaS && (grant_q || !memBusy);
        if (halt_q && startS && !startPrev_q) begin
            halt_d = 1'b0;
        end
        if (run) begin
            unique case (c.op)
                msd_pkg::OP_LOADR: begin
                    unique case (c.sel)
                        4'h1, 4'h9: t_d = lit;
                        4'h2: m_d = lit;
                        4'h3: begin
                            n_d = lit;
                            m_d = msd_pkg::BYTE_RST;
                        end
                        4'h6: u_d = lit;
                        4'h7: begin
                            halt_d = lit[7];
                            serEn_d = lit[0];
                        end
                        4'h4, 4'h5, 4'hc, 4'hd: begin
                            redirect = 1'b1;
                            target = {c.sel[3], c.sel[0], lit};
                        end
                        default: ;
                    endcase
                end
                msd_pkg::OP_MEM: begin
                    memCnt_d = 3'h1;
                    memWr_d = c.sel[0];
                    memFull_d = !c.sel[1];
                    wrData_d = t_q;
                end
                msd_pkg::OP_ADDL: fileWe = 1'b1;
                msd_pkg::OP_CTRL: ioc_d = c.opt[2:0];
                default: ;
            endcase
            if (isOpr && c.op != msd_pkg::OP_CTRL) begin
                fileWe = !c.inhibit && c.op != msd_pkg::OP_CMP;
                if (c.op <= msd_pkg::OP_SHF) begin
                    link_d = cy;
                    if (c.opt[0]) begin
                        flags_d = {zero && (!c.opt[3] || flags_q[2]),
                                   res[7], ovf};
                    end
                end
                if (c.op == msd_pkg::OP_CMP && zero) begin
                    redirect = 1'b1;
                end
                unique case (c.dest)
                    msd_pkg::DST_T: t_d = res;
                    msd_pkg::DST_M: m_d = res;
                    msd_pkg::DST_N: n_d = res;
                    msd_pkg::DST_LLO, msd_pkg::DST_LHI: begin
                        redirect = 1'b1;
                        target = {pc_q[9], c.dest[0], res};
                    end
                    msd_pkg::DST_U, msd_pkg::DST_UOR: u_d = res;
                    default: ;
                endcase
            end
            if (halt_d) begin
                cmd_d = msd_pkg::NOP_CMD;
            end else if (redirect) begin
                pc_d = target;
                cmd_d = msd_pkg::NOP_CMD;
            end else begin
                pc_d = {pc_q[9:8], pc_q[7:0] + 8'h01};
                cmd_d = modWord(rosData, u_q);
            end
        end
        // the arriving byte wins over a T write in the same clock
        if (memBusy && !memWr_q && memCnt_q == msd_pkg::RD_LOAD_CLK) begin
            t_d = memRdData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_q <= msd_pkg::PC_RST;
            cmd_q <= msd_pkg::NOP_CMD;
            t_q <= msd_pkg::BYTE_RST;
            m_q <= msd_pkg::BYTE_RST;
            n_q <= msd_pkg::BYTE_RST;
            u_q <= msd_pkg::BYTE_RST;
            wrData_q <= msd_pkg::BYTE_RST;
            ioc_q <= 3'h0;
            flags_q <= 3'h0;
            memCnt_q <= 3'h0;
            link_q <= 1'b0;
            halt_q <= 1'b0;
            serEn_q <= 1'b0;
            startPrev_q <= 1'b0;
            memFull_q <= 1'b0;
            memWr_q <= 1'b0;
            grant_q <= 1'b0;
            for (int i = 1; i < 16; i++) begin
                file_q[i] <= msd_pkg::BYTE_RST;
            end
        end else begin
            pc_q <= pc_d;
            cmd_q <= cmd_d;
            t_q <= t_d;
            m_q <= m_d;
            n_q <= n_d;
            u_q <= u_d;
            wrData_q <= wrData_d;
            ioc_q <= ioc_d;
            flags_q <= (fileWe && fileIdx == 4'h0) ? fileVal[2:0] : flags_d;
            memCnt_q <= memCnt_d;
            link_q <= link_d;
            halt_q <= halt_d;
            serEn_q <= serEn_d;
            startPrev_q <= startS;
            memFull_q <= memFull_d;
            memWr_q <= memWr_d;
            grant_q <= grant_d;
            if (fileWe && fileIdx != 4'h0) begin
                file_q[fileIdx] <= fileVal;
            end
        end
    end

    // ==========================================
    // outputs
    assign rosAddr = pc_q;
    assign memAddr = {m_q[6:0], n_q};
    assign memAddrOe = !grant_q;
    assign memStart = memCnt_q == 3'h1;
    assign memWrite = memWr_q;
    assign memFull = memFull_q;
    assign memWrData = wrData_q;
    assign dmaGrant = grant_q;
    assign ioCtl = ioc_q;
    assign halted = halt_q;

    // ==========================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence fullSeq;
        memStart && memFull ##0 memBusy [*5] ##1 !memBusy;
    endsequence
    sequence halfSeq;
        memStart && !memFull ##0 memBusy [*3] ##1 !memBusy;
    endsequence
    addr_release_a: assert property (grant_q |-> !memAddrOe)
        else $error("address bus driven during dma");
    addr_form_a: assert property (memAddr[14:8] == m_q[6:0]
        && memAddr[7:0] == n_q) else $error("bad memory address");
    pc_count_a: assert property (run && !redirect && !halt_d
        |=> pc_q[7:0] == $past(pc_q[7:0]) + 8'h01)
        else $error("program counter did not step");
    cmd_mod_a: assert property (run && !redirect && !halt_d
        && rosData[15:12] == 4'h0 |=> cmd_q[15:8] == $past(rosData[15:8]
        | u_q)) else $error("modifier not merged");
    full_len_a: assert property (memStart && memFull |-> fullSeq)
        else $error("full cycle length wrong");
    half_len_a: assert property (memStart && !memFull |-> halfSeq)
        else $error("half cycle length wrong");
    read_load_a: assert property (memStart && !memWrite
        |=> ##1 t_q == $past(memRdData)) else $error("read byte not in T");
    dma_first_a: assert property (dmaS && !grant_q
        |=> !(memStart && $past(c.op == msd_pkg::OP_MEM)))
        else $error("processor beat dma");
    mn_hold_a: assert property (grant_q |=> $stable(m_q)
        && $stable(n_q)) else $error("address register moved under dma");
    halt_pc_a: assert property (halt_q && $past(halt_q)
        |-> $stable(pc_q)) else $error("pc moved while halted");
    refetch_a: assert property (run && redirect && !halt_d
        |=> cmd_q == msd_pkg::NOP_CMD && pc_q == $past(target))
        else $error("no refetch bubble");
    ioc_only_a: assert property (c.op != msd_pkg::OP_CTRL
        |=> $stable(ioc_q)) else $error("io control changed");
endmodule // msd_core
`default_nettype wire

// ===== design/msd_pkg.sv
`default_nettype none
package msd_pkg;
    // ==========================================
    // machine timing, in ns and in machine clocks
    localparam int MACH_CYCLE_NS = 220;
    localparam int FULL_CYCLE_NS = 1100;
    localparam int HALF_CYCLE_NS = 660;
    localparam int RD_LOAD_NS = 440;
    localparam logic [2:0] FULL_CLKS = 3'(FULL_CYCLE_NS / MACH_CYCLE_NS);
    localparam logic [2:0] HALF_CLKS = 3'(HALF_CYCLE_NS / MACH_CYCLE_NS);
    localparam logic [2:0] RD_LOAD_CLK = 3'(RD_LOAD_NS / MACH_CYCLE_NS);
    // ==========================================
    // opcodes
    localparam logic [3:0] OP_EXEC = 4'h0;
    localparam logic [3:0] OP_LOADR = 4'h1;
    localparam logic [3:0] OP_MEM = 4'h2;
    localparam logic [3:0] OP_ADDL = 4'h3;
    localparam logic [3:0] OP_CTRL = 4'h7;
    localparam logic [3:0] OP_ADD = 4'h8;
    localparam logic [3:0] OP_SUB = 4'h9;
    localparam logic [3:0] OP_CMP = 4'ha;
    localparam logic [3:0] OP_SHF = 4'hb;
    localparam logic [3:0] OP_AND = 4'hc;
    localparam logic [3:0] OP_OR = 4'hd;
    localparam logic [3:0] OP_XOR = 4'he;
    localparam logic [3:0] OP_COPY = 4'hf;
    // ==========================================
    // operate destinations
    localparam logic [2:0] DST_NONE = 3'h0;
    localparam logic [2:0] DST_T = 3'h1;
    localparam logic [2:0] DST_M = 3'h2;
    localparam logic [2:0] DST_N = 3'h3;
    localparam logic [2:0] DST_LLO = 3'h4;
    localparam logic [2:0] DST_LHI = 3'h5;
    localparam logic [2:0] DST_U = 3'h6;
    localparam logic [2:0] DST_UOR = 3'h7;
    // ==========================================
    // flag entry bit positions
    localparam int FLG_OVF = 0;
    localparam int FLG_NEG = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_IOREQ = 3;
    localparam int FLG_INTIRQ = 4;
    localparam int FLG_REPLY = 5;
    localparam int FLG_SERIAL = 6;
    localparam int FLG_EXTIRQ = 7;
    // ==========================================
    // reset values
    localparam logic [9:0] PC_RST = 10'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] NOP_CMD = 16'h1700;
    typedef struct packed {
        logic [3:0] op;
        logic [3:0] sel;
        logic [3:0] opt;
        logic inhibit;
        logic [2:0] dest;
    } msd_cmd_t;
endpackage
`default_nettype wire

// ===== testbench/msd_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module msd_far_model (
    // clock
    input wire logic clk,
    // read-only store
    input wire logic [9:0] rosAddr,
    output logic [15:0] rosData,
    // core memory
    input wire logic [14:0] memAddr,
    input wire logic memStart,
    input wire logic memWrite,
    input wire logic [7:0] memWrData,
    output logic [7:0] memRdData
);
    // ==========================================
    // storage
    logic [15:0] rom [1024];
    logic [7:0] mem [32768];
    logic [14:0] addr_q = 15'h0000;
    logic rd_q = 1'b0;
    logic [2:0] cnt_q = 3'h0;
    // ==========================================
    // answers
    assign rosData = rom[rosAddr];
    // byte valid only in its sampling cycle, inverted otherwise
    assign memRdData = (rd_q && cnt_q == 3'h2) ? mem[addr_q] :
        ~mem[addr_q];
    always @(posedge clk) begin
        if (memStart) begin
            addr_q <= memAddr;
            rd_q <= !memWrite;
            cnt_q <= 3'h2;
            if (memWrite) begin
                mem[memAddr] <= memWrData;
            end
        end else if (cnt_q != 3'h0) begin
            cnt_q <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
        end
    end
endmodule // msd_far_model
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] rosAddr;
    logic [15:0] rosData;
    logic [14:0] memAddr;
    logic memAddrOe, memStart, memWrite, memFull, dmaGrant, halted;
    logic [7:0] memWrData, memRdData;
    logic [2:0] ioCtl;
    logic [7:0] ioIn = 8'h00;
    logic dmaReq = 1'b0, ioRequest = 1'b0, ioReply = 1'b0;
    logic extIrq = 1'b0, intIrq = 1'b0, serialIn = 1'b0, startReq = 1'b0;
    int errors = 0;
    int n_checks = 0;
    always #5 clk = ~clk;
    msd_core msd_core_i (.clk(clk), .rst(rst), .rosAddr(rosAddr),
        .rosData(rosData), .memAddr(memAddr), .memAddrOe(memAddrOe),
        .memStart(memStart), .memWrite(memWrite), .memFull(memFull),
        .memWrData(memWrData), .memRdData(memRdData), .dmaReq(dmaReq),
        .dmaGrant(dmaGrant), .ioIn(ioIn), .ioCtl(ioCtl),
        .ioRequest(ioRequest), .ioReply(ioReply), .extIrq(extIrq),
        .intIrq(intIrq), .serialIn(serialIn), .startReq(startReq),
        .halted(halted));
    msd_far_model msd_far_model_i (.clk(clk), .rosAddr(rosAddr),
        .rosData(rosData), .memAddr(memAddr), .memStart(memStart),
        .memWrite(memWrite), .memWrData(memWrData),
        .memRdData(memRdData));
    // ==========================================
    // helpers
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put(input int a, input logic [15:0] w);
        msd_far_model_i.rom[a] = w;
    endtask
    task automatic wipe();
        for (int i = 0; i < 1024; i++) begin
            put(i, msd_pkg::NOP_CMD);
        end
    endtask
    task automatic boot();
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return memStart;
            1: return dmaGrant;
            2: return halted;
            default: return rosAddr === 10'h001;
        endcase
    endfunction
    // cycles waited come back in n; a stuck wait ends the run
    task automatic wait_for(input int s, input logic v, output int n);
        n = 0;
        while (pick(s) !== v) begin
            tick(1);
            n++;
            if (n > 300) begin
                chk(1'b0, "bounded wait ran out");
                give_verdict();
            end
        end
    endtask
    // ==========================================
    // scenarios
    task automatic t_fetch();
        logic [9:0] exp [5];
        int n;
        exp = '{10'h002, 10'h003, 10'h2fe, 10'h2ff, 10'h200};
        wipe();
        put(2, 16'h1cfe);
        put(3, 16'h7158);
        put(10'h2fe, 16'h7138);
        boot();
        chk(rosAddr === msd_pkg::PC_RST, "pc after reset");
        wait_for(3, 1'b1, n);
        for (int i = 0; i < 5; i++) begin
            tick(1);
            chk(rosAddr === exp[i], "fetch order");
            chk(ioCtl !== 3'h5, "skipped word ran");
        end
        tick(1);
        chk(ioCtl === 3'h3, "jump target not run");
        $display("test fetch done");
    endtask
    task automatic t_mem();
        int n;
        wipe();
        put(0, 16'h1334);
        put(1, 16'h12f5);
        put(2, 16'h115a);
        put(3, 16'h2000);
        put(4, 16'h2300);
        put(5, 16'h2100);
        msd_far_model_i.mem[15'h7534] = 8'hc3;
        boot();
        wait_for(0, 1'b1, n);
        chk(memAddr === 15'h7534, "address from M and N");
        chk(memAddrOe === 1'b1, "address not driven");
        chk(memWrite === 1'b0 && memFull === 1'b1, "full read");
        tick(1);
        wait_for(0, 1'b1, n);
        // one idle clock separates a cycle from the next start
        chk(n == msd_pkg::FULL_CLKS, "full cycle length");
        chk(memWrite === 1'b1 && memFull === 1'b0, "half write");
        chk(memWrData === 8'hc3, "read byte not in T");
        tick(1);
        wait_for(0, 1'b1, n);
        chk(n == msd_pkg::HALF_CLKS, "half cycle length");
        chk(memFull === 1'b1 && memWrData === 8'hc3, "full write");
        $display("test memory done");
    endtask
    task automatic t_dma();
        logic [14:0] a;
        int n;
        wipe();
        put(0, 16'h1334);
        put(1, 16'h12f5);
        put(20, 16'h2000);
        boot();
        tick(6);
        a = memAddr;
        chk(a === 15'h7534, "address before dma");
        @(posedge clk);
        dmaReq <= 1'b1;
        wait_for(1, 1'b1, n);
        chk(memAddrOe === 1'b0, "address still driven");
        repeat (30) begin
            tick(1);
            chk(memStart === 1'b0, "processor beat dma");
            chk(memAddr === a, "address moved");
        end
        @(posedge clk);
        dmaReq <= 1'b0;
        wait_for(1, 1'b0, n);
        chk(memAddrOe === 1'b1, "address not restored");
        wait_for(0, 1'b1, n);
        chk(memAddr === a, "address lost");
        $display("test dma done");
    endtask
    task automatic t_ioctl();
        for (int v = 0; v < 8; v++) begin
            wipe();
            put(4, {8'h71, 1'b0, 3'(v), 4'h8});
            boot();
            tick(10);
            chk(ioCtl === 3'(v), "control value");
        end
        wipe();
        put(4, 16'h1670);
        // lookahead fetches the next word with the old modifier
        put(6, 16'h0128);
        boot();
        tick(10);
        chk(ioCtl === 3'h2, "execute modify");
        $display("test control done");
    endtask
    task automatic t_flags();
        int n;
        @(posedge clk);
        ioRequest <= 1'b1;
        ioReply <= 1'b1;
        extIrq <= 1'b1;
        intIrq <= 1'b1;
        serialIn <= 1'b1;
        ioIn <= 8'h6c;
        wipe();
        put(3, 16'h1701);
        put(4, 16'h8009);
        put(5, 16'h2100);
        put(6, 16'h7148);
        put(7, 16'h8129);
        put(8, 16'h2100);
        boot();
        wait_for(0, 1'b1, n);
        chk(memWrData === 8'hf8, "flag entry lines");
        tick(1);
        wait_for(0, 1'b1, n);
        chk(memWrData === 8'h6c, "input bus not used");
        chk(ioCtl === 3'h4, "input flag");
        $display("test flags done");
    endtask
    // equal compare skips the M load and leaves carry set for the shift
    task automatic t_alu();
        int n;
        wipe();
        put(0, 16'h1105);
        put(1, 16'h3205);
        put(2, 16'ha220);
        put(3, 16'h1203);
        put(4, 16'hb101);
        put(5, 16'h2300);
        boot();
        wait_for(0, 1'b1, n);
        chk(memAddr === 15'h0000, "skipped word ran");
        chk(memWrData === 8'h01, "carry not shifted in");
        $display("test alu done");
    endtask
    task automatic t_halt();
        logic [9:0] a;
        int n;
        wipe();
        put(5, 16'h1780);
        boot();
        wait_for(2, 1'b1, n);
        a = rosAddr;
        chk(a === 10'h006 || a === 10'h007, "halt address");
        tick(8);
        chk(rosAddr === a && halted === 1'b1, "pc moved");
        @(posedge clk);
        startReq <= 1'b1;
        tick(4);
        @(posedge clk);
        startReq <= 1'b0;
        wait_for(2, 1'b0, n);
        tick(3);
        chk(rosAddr !== a, "no restart");
        $display("test halt done");
    endtask
    initial begin
        t_fetch();
        t_mem();
        t_dma();
        t_ioctl();
        t_flags();
        t_alu();
        t_halt();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
